// file: core/bb_mod_pkg.sv
// Shared constants of the baseband I/Q modulator: clocks, widths, register map and fields.
package bb_mod_pkg;

    // Clock rates; the modulator advances on an enable pulse at the baseband rate.
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int BB_CLK_HZ  = 4_930_000;
    localparam int BB_DIV     = SYS_CLK_HZ / BB_CLK_HZ;

    // Datapath widths and sizes.
    localparam int PHASE_W     = 12;
    localparam int SAMPLE_W    = 9;
    localparam int MAG_W       = 8;
    localparam int ROM_ENTRIES = 128;
    localparam int ROM_AW      = 7;
    localparam int RAM_DEPTH   = 64;
    localparam int RAM_AW      = 6;
    localparam int BYTE_W      = 8;
    localparam int FIFO_DEPTH  = 8;
    localparam int HOLD_W      = 9;

    // Phase offset of a quarter turn, used to derive cosine from the sine fold.
    localparam logic [PHASE_W-1:0] QUARTER_TURN = 12'h400;

    // Register offsets on the special-function register port.
    localparam logic [7:0] ADDR_BAND     = 8'hc2;
    localparam logic [7:0] ADDR_RAM_DATA = 8'hc9;
    localparam logic [7:0] ADDR_RAM_PTR  = 8'hca;
    localparam logic [7:0] ADDR_TX_BUF   = 8'hcb;
    localparam logic [7:0] ADDR_STEP     = 8'hd1;
    localparam logic [7:0] ADDR_SCALE    = 8'hd2;
    localparam logic [7:0] ADDR_CTRL     = 8'hd3;
    localparam logic [7:0] ADDR_STATE    = 8'heb;

    // Field positions.
    localparam int BAND_BIT      = 7;
    localparam int CTRL_POLARITY = 5;
    localparam int CTRL_MOD_EN   = 4;
    localparam int CTRL_ASK      = 3;
    localparam int CTRL_RAM_LOAD = 2;
    localparam int CTRL_SHIFT_EN = 1;
    localparam int STATE_BUSY    = 7;
    localparam int STATE_ONE     = 6;

    // Reset values and the index of the last bit of a byte.
    localparam logic BAND_RESET = 1'b1;
    localparam logic CTRL_BIT_RESET = 1'b0;
    localparam logic [2:0] BIT_LAST = 3'h7;

endpackage

// file: core/sample_fifo_if.sv
// Interface carrying I/Q sample words between the modulator and its sample FIFO.
`timescale 1ns/1ps
`default_nettype none
interface sample_fifo_if #(
    parameter int WIDTH = 18
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic             flush;

    // Storage side of the FIFO.
    modport store (
        input  push_valid, push_data, pop_ready, flush,
        output push_ready, pop_valid, pop_data
    );

    // User side: pushes generated samples and drains them towards the DACs.
    modport user (
        output push_valid, push_data, pop_ready, flush,
        input  push_ready, pop_valid, pop_data
    );
endinterface
`default_nettype wire

// file: core/sample_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides and a flush.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
    import bb_mod_pkg::*;
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic         clk_sys,
    input wire logic         sys_rst,
    // Sample stream
    sample_fifo_if.store     port
);
    localparam int AW = $clog2(DEPTH);

    // Pointers carry one extra bit so that full and empty stay distinguishable.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("sample_fifo depth must be a power of two of at least two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic        full;
    logic        empty;

    // Honest flags straight from the pointers.
    assign empty           = (st_reg.wr_ptr == st_reg.rd_ptr);
    assign full            = (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0])
                             && (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]);
    assign port.push_ready = ~full & ~port.flush;
    assign port.pop_valid  = ~empty & ~port.flush;
    assign port.pop_data   = st_reg.mem[st_reg.rd_ptr[AW-1:0]];

    // Push and pop may happen in the same cycle; flush empties the store at once.
    always_comb begin
        st_next = st_reg;
        if (port.flush) begin
            st_next.wr_ptr = '0;
            st_next.rd_ptr = '0;
        end else begin
            if (port.push_valid && !full) begin
                st_next.mem[st_reg.wr_ptr[AW-1:0]] = port.push_data;
                st_next.wr_ptr = st_reg.wr_ptr + {{AW{1'b0}}, 1'b1};
            end
            if (port.pop_ready && !empty) begin
                st_next.rd_ptr = st_reg.rd_ptr + {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // Stored words are left alone by reset; only the pointers need a value.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg.mem    <= st_next.mem;
            st_reg.wr_ptr <= '0;
            st_reg.rd_ptr <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// file: core/quarter_wave_rom.sv
// Quarter-wave magnitude table folded into a full signed sine sample.
`timescale 1ns/1ps
`default_nettype none
module quarter_wave_rom
    import bb_mod_pkg::*;
(
    // Phase in
    input wire logic [PHASE_W-1:0]         phase,
    // Signed sample out
    output logic signed [SAMPLE_W-1:0]     sample
);
    typedef logic [ROM_ENTRIES-1:0][MAG_W-1:0] rom_t;

    // Builds the 128-byte table at elaboration with a rational sine fit, so no
    // data file is needed; the fit stays within about two tenths of a percent.
    function automatic rom_t build_table();
        rom_t        tbl;
        longint      t;
        longint      prod;
        longint      num;
        longint      den;
        tbl = '0;
        for (int i = 0; i < ROM_ENTRIES; i++) begin
            t    = 2 * i + 1;
            prod = t * (512 - t);
            num  = 255 * 4 * prod;
            den  = 327680 - prod;
            // Rounded rather than truncated, so the peak entry reaches the full 255.
            tbl[i] = MAG_W'((num + den / 2) / den);
        end
        return tbl;
    endfunction

    localparam rom_t TABLE = build_table();

    logic [1:0]        quadrant;
    logic [ROM_AW-1:0] index;
    logic [MAG_W-1:0]  mag;

    // The two top phase bits pick the quadrant: odd ones mirror, upper half negates.
    assign quadrant = phase[PHASE_W-1 -: 2];
    assign index    = quadrant[0] ? ~phase[PHASE_W-3 -: ROM_AW] : phase[PHASE_W-3 -: ROM_AW];
    assign mag      = TABLE[index];
    assign sample   = quadrant[1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
endmodule
`default_nettype wire

// file: core/baseband_iq_modulator.sv
// Baseband I/Q modulator: register port, transmit RAM, bit sequencer and phase-step generator.
`timescale 1ns/1ps
`default_nettype none
module baseband_iq_modulator
    import bb_mod_pkg::*;
#(
    parameter int CLK_DIV = BB_DIV
) (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  sys_rst,
    // Special-function register port
    input wire logic [7:0]            sfr_addr,
    input wire logic [7:0]            sfr_wdata,
    input wire logic                  sfr_wr,
    input wire logic                  sfr_rd,
    output logic [7:0]                sfr_rdata,
    // I/Q DAC side
    input wire logic                  dac_ready,
    output logic [SAMPLE_W-1:0]       dac_i,
    output logic [SAMPLE_W-1:0]       dac_q,
    output logic                      dac_strobe,
    // Carrier synthesiser control
    output logic                      carrier_band_sel
);
    localparam int DIV_W = $clog2(CLK_DIV + 1);
    localparam int WORD_W = 2 * SAMPLE_W;

    // The divider needs at least two system clocks per baseband step.
    if (CLK_DIV < 2) begin : g_bad_div
        $error("baseband_iq_modulator clock divider must be at least two");
    end

    typedef struct packed {
        logic [DIV_W-1:0]                 div_cnt;
        logic                             tick_pend;
        logic                             band;
        logic                             polarity;
        logic                             mod_en;
        logic                             ask_mode;
        logic                             ram_load;
        logic                             shift_en;
        logic [BYTE_W-1:0]                base_step;
        logic [BYTE_W-1:0]                scale;
        logic [RAM_AW-1:0]                ram_ptr;
        logic [BYTE_W-1:0]                ram_wbyte;
        logic [BYTE_W-1:0]                hold_buf;
        logic [RAM_DEPTH-1:0][BYTE_W-1:0] ram;
        logic                             pending;
        logic                             active;
        logic [BYTE_W-1:0]                shifter;
        logic [2:0]                       bit_idx;
        logic [PHASE_W-1:0]               phase;
        logic [HOLD_W-1:0]                hold_cnt;
        logic [RAM_AW-1:0]                addr_idx;
        logic [SAMPLE_W-1:0]              out_i;
        logic [SAMPLE_W-1:0]              out_q;
        logic                             out_stb;
        logic [7:0]                       rdata;
    } mod_state_t;

    mod_state_t st_reg;
    mod_state_t st_next;

    sample_fifo_if #(.WIDTH(WORD_W)) fifo ();

    sample_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .port    (fifo.store)
    );

    logic                       gen_run;
    logic                       gen_go;
    logic                       cur_bit;
    logic [BYTE_W-1:0]          dev_byte;
    logic [PHASE_W-1:0]         base4;
    logic [PHASE_W-1:0]         dev12;
    logic [PHASE_W-1:0]         step;
    logic [HOLD_W-1:0]          hold_len;
    logic                       sample_end;
    logic                       bit_end;
    logic [PHASE_W-1:0]         cos_phase;
    logic signed [SAMPLE_W-1:0] sin_s;
    logic signed [SAMPLE_W-1:0] cos_s;
    logic [SAMPLE_W-1:0]        samp_i;
    logic [SAMPLE_W-1:0]        samp_q;
    logic                       amp_on;

    // One table per channel; cosine is the sine a quarter turn ahead.
    quarter_wave_rom u_rom_sin (
        .phase  (st_reg.phase),
        .sample (sin_s)
    );

    quarter_wave_rom u_rom_cos (
        .phase  (cos_phase),
        .sample (cos_s)
    );

    // Generator runs only when enabled and the RAM is not being loaded.
    assign gen_run   = st_reg.mod_en & ~st_reg.ram_load;
    // A baseband step waits for FIFO room, so a stalled DAC stalls the whole sequence.
    assign gen_go    = gen_run & st_reg.tick_pend & fifo.push_ready;
    assign cur_bit   = st_reg.active & st_reg.shifter[BYTE_W-1];
    assign dev_byte  = st_reg.ram[st_reg.addr_idx];
    assign base4     = {2'b00, st_reg.base_step, 2'b00};
    assign dev12     = {4'h0, dev_byte};
    assign cos_phase = st_reg.phase + QUARTER_TURN;

    // FSK moves the step up or down by the RAM byte; ASK keeps the summed step.
    always_comb begin
        if (st_reg.ask_mode) begin
            step = base4 + dev12;
        end else if (cur_bit) begin
            step = base4 + dev12;
        end else begin
            step = base4 - dev12;
        end
    end

    // Each RAM sample is held for twice the scale, matching the half in the bit rate.
    assign hold_len   = {st_reg.scale, 1'b0};
    assign sample_end = (st_reg.hold_cnt + 9'h001) >= hold_len;
    assign bit_end    = sample_end && (({1'b0, st_reg.addr_idx} + 7'h01) >= {1'b0, st_reg.ram_ptr});

    // ASK keys the amplitude off for a zero bit.
    assign amp_on = ~st_reg.ask_mode | cur_bit;

    // Upper sideband puts cosine on I; polarity one swaps the channels.
    always_comb begin
        if (!amp_on) begin
            samp_i = '0;
            samp_q = '0;
        end else if (st_reg.polarity) begin
            samp_i = sin_s;
            samp_q = cos_s;
        end else begin
            samp_i = cos_s;
            samp_q = sin_s;
        end
    end

    // FIFO hookup: push generated samples, drain whenever the DAC accepts.
    assign fifo.push_valid = gen_go;
    assign fifo.push_data  = {samp_i, samp_q};
    assign fifo.pop_ready  = dac_ready & st_reg.mod_en;
    assign fifo.flush      = ~gen_run;

    // Next-state logic for the register port, the sequencer and the output stage.
    always_comb begin
        st_next = st_reg;
        st_next.out_stb = 1'b0;
        st_next.rdata = 8'h00;

        // Baseband enable divider; a missed step is held until the FIFO has room.
        if (st_reg.div_cnt == DIV_W'(CLK_DIV - 1)) begin
            st_next.div_cnt = '0;
            st_next.tick_pend = 1'b1;
        end else begin
            st_next.div_cnt = st_reg.div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
        end
        if (gen_go) begin
            st_next.tick_pend = 1'b0;
        end

        // One phase step per baseband clock, wrapping modulo a full turn.
        if (gen_go) begin
            st_next.phase = st_reg.phase + step;
            if (sample_end) begin
                st_next.hold_cnt = '0;
                if (bit_end) begin
                    st_next.addr_idx = '0;
                end else begin
                    st_next.addr_idx = st_reg.addr_idx + 6'h01;
                end
            end else begin
                st_next.hold_cnt = st_reg.hold_cnt + 9'h001;
            end
        end

        // Bit boundary: shift the buffer, or take the pending byte when it runs out.
        if (gen_go && bit_end && st_reg.shift_en) begin
            if (!st_reg.active || st_reg.bit_idx == BIT_LAST) begin
                st_next.active = st_reg.pending;
                st_next.shifter = st_reg.hold_buf;
                st_next.bit_idx = '0;
                st_next.pending = 1'b0;
            end else begin
                st_next.shifter = {st_reg.shifter[BYTE_W-2:0], 1'b0};
                st_next.bit_idx = st_reg.bit_idx + 3'h1;
            end
        end

        // Phase, hold count and RAM index restart from the top each time modulation is switched off.
        if (!gen_run) begin
            st_next.phase = '0;
            st_next.hold_cnt = '0;
            st_next.addr_idx = '0;
            st_next.tick_pend = 1'b0;
        end

        // Register writes; a new byte written in the cycle it is consumed stays pending.
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_BAND: begin
                    st_next.band = sfr_wdata[BAND_BIT];
                end
                ADDR_CTRL: begin
                    st_next.polarity = sfr_wdata[CTRL_POLARITY];
                    st_next.mod_en = sfr_wdata[CTRL_MOD_EN];
                    st_next.ask_mode = sfr_wdata[CTRL_ASK];
                    st_next.ram_load = sfr_wdata[CTRL_RAM_LOAD];
                    st_next.shift_en = sfr_wdata[CTRL_SHIFT_EN];
                end
                ADDR_STEP: begin
                    st_next.base_step = sfr_wdata;
                end
                ADDR_SCALE: begin
                    st_next.scale = sfr_wdata;
                end
                ADDR_RAM_PTR: begin
                    st_next.ram_ptr = sfr_wdata[RAM_AW-1:0];
                end
                ADDR_RAM_DATA: begin
                    st_next.ram_wbyte = sfr_wdata;
                    if (st_reg.ram_load) begin
                        st_next.ram[st_reg.ram_ptr] = sfr_wdata;
                    end
                end
                ADDR_TX_BUF: begin
                    st_next.hold_buf = sfr_wdata;
                    st_next.pending = 1'b1;
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end

        // Only the state register reads back; the rest are write-only and read zero.
        if (sfr_rd && sfr_addr == ADDR_STATE) begin
            st_next.rdata[STATE_BUSY] = st_next.pending;
            st_next.rdata[STATE_ONE] = 1'b1;
        end

        // DAC stage: registered words, zero while modulation is off.
        if (!st_reg.mod_en) begin
            st_next.out_i = '0;
            st_next.out_q = '0;
        end else if (fifo.pop_valid && dac_ready) begin
            st_next.out_i = fifo.pop_data[WORD_W-1 -: SAMPLE_W];
            st_next.out_q = fifo.pop_data[SAMPLE_W-1:0];
            st_next.out_stb = 1'b1;
        end
    end

    // Control state resets; data registers and RAM keep whatever they held.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg <= st_next;
            st_reg.div_cnt <= '0;
            st_reg.tick_pend <= 1'b0;
            st_reg.band <= BAND_RESET;
            st_reg.polarity <= CTRL_BIT_RESET;
            st_reg.mod_en <= CTRL_BIT_RESET;
            st_reg.ask_mode <= CTRL_BIT_RESET;
            st_reg.ram_load <= CTRL_BIT_RESET;
            st_reg.shift_en <= CTRL_BIT_RESET;
            st_reg.pending <= 1'b0;
            st_reg.active <= 1'b0;
            st_reg.shifter <= '0;
            st_reg.bit_idx <= '0;
            st_reg.phase <= '0;
            st_reg.hold_cnt <= '0;
            st_reg.addr_idx <= '0;
            st_reg.out_i <= '0;
            st_reg.out_q <= '0;
            st_reg.out_stb <= 1'b0;
            st_reg.rdata <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flip-flops.
    assign sfr_rdata        = st_reg.rdata;
    assign dac_i            = st_reg.out_i;
    assign dac_q            = st_reg.out_q;
    assign dac_strobe       = st_reg.out_stb;
    assign carrier_band_sel = st_reg.band;
endmodule
`default_nettype wire

// file: tb/bb_dac_model.sv
// Behavioural I/Q DAC pair that takes sample words with random and forced back-pressure.
`timescale 1ns/1ps
`default_nettype none
module bb_dac_model (
    input wire logic clk_sys,
    input wire logic stall,
    output logic     dac_ready
);
    // Ready changes just after each edge; random gaps keep the FIFO moving between levels.
    initial dac_ready = 1'b0;
    always @(posedge clk_sys) begin
        #1 dac_ready = !stall && ($urandom % 4 != 0);
    end
endmodule
`default_nettype wire

// file: tb/bb_mod_checker.sv
// Port-level assertions of the baseband I/Q modulator, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module bb_mod_checker
    import bb_mod_pkg::*;
#(
    parameter int CLK_DIV = BB_DIV
) (
    input wire logic                clk_sys,
    input wire logic                sys_rst,
    input wire logic [7:0]          sfr_addr,
    input wire logic [7:0]          sfr_wdata,
    input wire logic                sfr_wr,
    input wire logic                sfr_rd,
    input wire logic [7:0]          sfr_rdata,
    input wire logic                dac_ready,
    input wire logic [SAMPLE_W-1:0] dac_i,
    input wire logic [SAMPLE_W-1:0] dac_q,
    input wire logic                dac_strobe,
    input wire logic                carrier_band_sel
);
    localparam int WAIT_MAX = 2 * CLK_DIV + 6;
    logic en_reg;
    logic en_next;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Shadow of the enable bit, so quiet and running periods can be told apart.
    assign en_next = (sfr_wr && sfr_addr == ADDR_CTRL) ? sfr_wdata[CTRL_MOD_EN] : en_reg;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            en_reg <= 1'b0;
        end else begin
            en_reg <= en_next;
        end
    end
    sequence state_read;
        sfr_rd && sfr_addr == ADDR_STATE;
    endsequence
    sequence quiet;
        (!en_reg) [*3];
    endsequence
    sequence fed;
        (en_reg && dac_ready) [*4];
    endsequence
    AST_RST_BAND: assert property (disable iff (1'b0) sys_rst |=> carrier_band_sel)
        else $error("band bit not set by reset");
    AST_BAND_WRITE: assert property (sfr_wr && sfr_addr == ADDR_BAND |=> carrier_band_sel == $past(sfr_wdata[BAND_BIT]))
        else $error("band write not applied");
    AST_BAND_HOLD: assert property ($changed(carrier_band_sel) |-> $past(sfr_wr && sfr_addr == ADDR_BAND))
        else $error("band bit moved without a write");
    AST_STATE_READ: assert property (state_read |=> sfr_rdata[6:0] == 7'h40)
        else $error("state read pattern wrong");
    AST_WRITE_ONLY: assert property (sfr_rdata != 8'h00 |-> $past(sfr_rd && sfr_addr == ADDR_STATE))
        else $error("read data from a write-only place");
    AST_QUIET_OFF: assert property (quiet |-> !dac_strobe && dac_i == '0 && dac_q == '0)
        else $error("output while modulation disabled");
    AST_STROBE_READY: assert property (dac_strobe |-> $past(dac_ready))
        else $error("sample delivered without ready");
    AST_STREAM_RUNS: assert property (fed |-> ##[0:WAIT_MAX] dac_strobe)
        else $error("no sample while enabled and ready");
    AST_HOLD_SAMPLE: assert property (!dac_strobe && en_reg && $past(en_reg) |-> $stable(dac_i) && $stable(dac_q))
        else $error("sample changed without strobe");
endmodule
bind baseband_iq_modulator bb_mod_checker #(.CLK_DIV(CLK_DIV)) u_chk (.clk_sys, .sys_rst, .sfr_addr, .sfr_wdata,
    .sfr_wr, .sfr_rd, .sfr_rdata, .dac_ready, .dac_i, .dac_q, .dac_strobe, .carrier_band_sel);
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the baseband I/Q modulator with a queued sample scoreboard.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bb_mod_pkg::*;
    localparam int DIV = 4;
    logic                clk_sys = 1'b0;
    logic                sys_rst = 1'b1;
    logic [7:0]          sfr_addr = 8'h00;
    logic [7:0]          sfr_wdata = 8'h00;
    logic                sfr_wr = 1'b0;
    logic                sfr_rd = 1'b0;
    logic                stall = 1'b0;
    logic [7:0]          sfr_rdata;
    logic                dac_ready;
    logic [SAMPLE_W-1:0] dac_i;
    logic [SAMPLE_W-1:0] dac_q;
    logic                dac_strobe;
    logic                carrier_band_sel;
    logic [17:0]         exp_q[$];
    logic [17:0]         note;
    logic [7:0]          rd_val;
    logic [7:0]          off;
    logic [7:0]          r;
    logic [7:0]          tx;
    int                  error_cnt = 0;
    int                  total_checks = 0;
    int                  cycles = 0;
    int                  bp;
    int                  sc;
    baseband_iq_modulator #(.CLK_DIV(DIV)) dut (.clk_sys, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
        .sfr_rdata, .dac_ready, .dac_i, .dac_q, .dac_strobe, .carrier_band_sel);
    bb_dac_model dac (.clk_sys, .stall, .dac_ready);
    always #5 clk_sys = ~clk_sys;
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and still reaches the verdict.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    // Register accesses last two cycles so a strobe never drops and rises in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk_sys);
        #1 sfr_wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk_sys);
        #1 sfr_rd = 1'b0;
        rd_val = sfr_rdata;
        @(posedge clk_sys);
        #1;
    endtask
    // Ideal sample with the table's peak of 255; the table is a fit, hence the tolerance below.
    function automatic logic [8:0] wave(input int p, input bit cosine);
        real a;
        a = 6.283185307 * p / 4096.0;
        return 9'(int'(255.0 * (cosine ? $cos(a) : $sin(a))));
    endfunction
    function automatic logic [8:0] near(input logic [8:0] seen, input logic [8:0] want);
        logic signed [9:0] d;
        d = $signed({seen[8], seen}) - $signed({want[8], want});
        return (d >= -2 && d <= 2) ? want : seen;
    endfunction
    // Oldest note meets each delivered word; words beyond the plan are left unchecked.
    always @(posedge clk_sys) begin
        if (dac_strobe === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check({near(dac_i, note[17:9]), near(dac_q, note[8:0])}, note);
        end
    end
    // The phase starts at 0 and each sample uses the phase before the add.
    task automatic plan(input int n, input int step, input bit pol, input bit ask, input int per);
        int ph;
        bit on;
        ph = 0;
        for (int k = 0; k < n; k++) begin
            on = !ask || (k >= per && k < 9 * per && tx[8 - k / per]);
            exp_q.push_back(on ? {wave(ph, !pol), wave(ph, pol)} : 18'h00000);
            ph = (ph + step) % 4096;
        end
    endtask
    task automatic load(input logic [5:0] ptr, input logic [7:0] scl);
        wr(ADDR_CTRL, 8'h04);
        for (int a = 0; a < RAM_DEPTH; a++) begin
            wr(ADDR_RAM_PTR, 8'(a));
            wr(ADDR_RAM_DATA, r);
        end
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_RAM_PTR, 8'h00);
        wr(ADDR_RAM_DATA, ~r); // Outside load mode this must not land
        wr(ADDR_RAM_PTR, {2'b00, ptr});
        wr(ADDR_SCALE, scl);
        wr(ADDR_STEP, off);
    endtask
    task automatic run(input logic [7:0] ctl, input int hold);
        int w;
        wr(ADDR_CTRL, ctl);
        repeat (hold) @(posedge clk_sys);
        #1 stall = 1'b0;
        for (w = 0; w < 3000 && exp_q.size() > 0; w++) @(posedge clk_sys);
        #1 check(18'(exp_q.size()), 18'h0);
        exp_q.delete();
    endtask
    initial begin
        void'($urandom(90046));
        repeat (6) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        rd(ADDR_STATE);
        check(18'(rd_val & 8'h7f), 18'h40);
        check(18'(carrier_band_sel), 18'h1);
        wr(ADDR_BAND, 8'h00);
        check(18'(carrier_band_sel), 18'h0);
        wr(ADDR_BAND, 8'h80);
        check(18'(carrier_band_sel), 18'h1);
        rd(ADDR_STEP);
        check(18'(rd_val), 18'h0);
        rd(8'h55);
        check(18'(rd_val), 18'h0);
        $display("Test registers done");
        // Idle FSK uses the minus deviation; the second pass also stalls the DAC so the FIFO fills.
        for (int p = 0; p < 2; p++) begin
            off = 8'($urandom_range(255, 1));
            r = 8'($urandom);
            load(6'($urandom_range(8, 1)), 8'($urandom_range(3, 1)));
            plan(40, int'((4 * off - r + 4096) % 4096), p[0], 1'b0, 1);
            stall = p[0];
            run(8'h10 | 8'(p << CTRL_POLARITY), 150);
            wr(ADDR_CTRL, 8'h00);
            repeat (6) @(posedge clk_sys);
            #1 check(18'({dac_i, dac_q}), 18'h0);
            $display("Test fsk pass %0d done", p);
        end
        // ASK keys the tone with the buffered byte, one bit per 2*scale*pointer steps.
        off = 8'($urandom_range(255, 1));
        r = 8'($urandom);
        bp = $urandom_range(2, 1);
        sc = $urandom_range(2, 1);
        load(6'(bp), 8'(sc));
        tx = 8'($urandom);
        wr(ADDR_TX_BUF, tx);
        rd(ADDR_STATE);
        check(18'(rd_val), 18'hc0);
        // The first bit period is silent until the byte is taken; eight bits follow, MSB first.
        plan(80, int'((4 * off + r) % 4096), 1'b0, 1'b1, 2 * sc * bp);
        run(8'h1a, 0);
        rd(ADDR_STATE);
        check(18'(rd_val), 18'h40);
        $display("Test ask done");
        conclude();
    end
endmodule
`default_nettype wire
